// ### srap_pkg.sv
package srap_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [6:0] TRICKLE_ADDR   = 7'h11;
    localparam logic [7:0] TRICKLE_RESET  = 8'h00;
    localparam logic [6:0] RTC_LAST       = 7'h1F;
    localparam logic [6:0] RTC_FIRST      = 7'h00;
    localparam logic [6:0] RAM_LAST       = 7'h7F;
    localparam logic [6:0] RAM_FIRST      = 7'h20;
    localparam logic [6:0] ALM_A_FIRST    = 7'h07;
    localparam logic [6:0] ALM_A_LAST     = 7'h0A;
    localparam logic [6:0] ALM_B_FIRST    = 7'h0B;
    localparam logic [6:0] ALM_B_LAST     = 7'h0E;
    localparam logic [3:0] CHARGE_KEY     = 4'hA;
    localparam logic [1:0] SEL_NONE       = 2'h0;
    localparam logic [1:0] DIODE_NONE     = 2'h1;
    localparam logic [1:0] DIODE_ONE      = 2'h2;
    localparam logic [1:0] RES_1K         = 2'h1;
    localparam logic [1:0] RES_2K         = 2'h2;
    localparam logic [1:0] RES_4K         = 2'h3;
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam int         ADDR_RW_BIT    = 7;
    localparam int         FIFO_DEPTH     = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRAP_IDLE,
        SRAP_ADDR,
        SRAP_DATA
    } srap_phase_t;

    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] data;
    } srap_req_t;

    typedef struct packed {
        logic       enable;
        logic       one_diode;
        logic [1:0] resistor;
    } srap_charge_t;
endpackage

// ### srap_fifo.sv
module srap_fifo
    import srap_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } srap_fifo_st_t;

    srap_fifo_st_t    st_ff;
    srap_fifo_st_t    nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             full;
    logic             empty;

    // Pointers carry one extra wrap bit for honest full/empty
    assign full      = (st_ff.wr[AW] != st_ff.rd[AW]) && (st_ff.wr[AW-1:0] == st_ff.rd[AW-1:0]);
    assign empty     = (st_ff.wr == st_ff.rd);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[st_ff.rd[AW-1:0]];

    // Pointer advance
    always_comb begin
        nxt_st = st_ff;
        if (in_valid && !full) begin
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (out_ready && !empty) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Storage has no reset; only written entries are ever read
    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[st_ff.wr[AW-1:0]] <= in_data;
        end
    end
endmodule

// ### srap_top.sv
// What this block does
// - Charging enabled only for key 1010
// - Charge register resets to all zeros
// - Diode field 01 none, 10 one, else off
// - Resistor 01/10/11 picks 1k/2k/4k, 00 off
// - Strap high four-wire, low three-wire
// - Slave only, separate in and out lines
// - Chip enable frames and aborts each transfer
// - Four-wire: clock level at enable picks edges
// - Four-wire bytes of eight, MSB first
// - First byte is address, top bit write
// - Four-wire reads out, writes in
// - Pointer increments after every data byte
// - Clock space wraps 1Fh to 00h
// - RAM space wraps 7Fh to 20h
// - Three-wire shared line, LSB first
// - Three-wire capture rising, change falling
// - Interrupt pins only pull low
// - Pointer on alarm registers clears flag
module srap_top
    import srap_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Serial pins
    input  wire logic       sclk,
    input  wire logic       ce,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdo_oe,
    input  wire logic       interface_select_strap,
    // Register side: reads come back combinationally by address
    output logic            req_valid,
    input  wire logic       req_ready,
    output srap_req_t       req,
    output logic [6:0]      rd_addr,
    input  wire logic [7:0] rd_data,
    // Alarm flags from the timekeeper
    input  wire logic       alarm_a_set,
    input  wire logic       alarm_b_set,
    input  wire logic       alarm_a_irq_en,
    input  wire logic       alarm_b_irq_en,
    output logic            alarm_a_flag,
    output logic            alarm_b_flag,
    // Open-drain interrupt pins
    output logic            irq_out_a,
    output logic            irq_out_a_oe,
    output logic            irq_out_b,
    output logic            irq_out_b_oe,
    // Charger controls
    output logic [7:0]      trickle_charge_control,
    output srap_charge_t    charge
);
    // ------------------------------------------------------------
    // Reset and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic       rst_n;
    logic [3:0] pin_s1_ff;
    logic [3:0] pin_s2_ff;
    logic       sclk_s;
    logic       ce_s;
    logic       sdi_s;
    logic       strap_s;

    // Reset enters asynchronously, released on the clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Pins come from the master's domain; first stage read only by second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
        end else begin
            pin_s1_ff <= {interface_select_strap, sdi, ce, sclk};
            pin_s2_ff <= pin_s1_ff;
        end
    end
    assign sclk_s  = pin_s2_ff[0];
    assign ce_s    = pin_s2_ff[1];
    assign sdi_s   = pin_s2_ff[2];
    assign strap_s = pin_s2_ff[3];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        srap_phase_t phase;
        logic        sclk_d;
        logic        idle_pol;
        logic        four_wire;
        logic [2:0]  bit_cnt;
        logic [7:0]  shift;
        logic [7:0]  tx;
        logic        write;
        logic [6:0]  ptr;
        logic        driving;
        logic        sdo_o;
        logic        req_v;
        srap_req_t   req_q;
        logic [7:0]  tcc;
        logic        flag_a;
        logic        flag_b;
        logic        irq_a;
        logic        irq_b;
        srap_charge_t chg;
    } srap_st_t;

    srap_st_t st_ff;
    srap_st_t nxt_st;
    logic     fifo_ready;
    logic     rise;
    logic     fall;
    logic     strobe;
    logic     shift_edge;
    logic     in_bit;
    logic [7:0] byte_in;
    logic [6:0] ptr_inc;
    logic [7:0] rd_byte;

    assign rise = sclk_s && !st_ff.sclk_d;
    assign fall = !sclk_s && st_ff.sclk_d;

    // Idle low: sample on falling, shift on rising (modes 1/3)
    assign strobe     = st_ff.four_wire ? (st_ff.idle_pol ? rise : fall) : rise;
    assign shift_edge = st_ff.four_wire ? (st_ff.idle_pol ? fall : rise) : fall;
    assign in_bit     = sdi_s;

    // Assembled byte; four-wire shifts in at bit 0, three-wire at bit 7
    assign byte_in = st_ff.four_wire ? {st_ff.shift[6:0], in_bit}
                                     : {in_bit, st_ff.shift[7:1]};

    // Pointer wraps inside its own space
    always_comb begin
        if (st_ff.ptr == RTC_LAST) begin
            ptr_inc = RTC_FIRST;
        end else if (st_ff.ptr == RAM_LAST) begin
            ptr_inc = RAM_FIRST;
        end else begin
            ptr_inc = st_ff.ptr + 7'h01;
        end
    end

    // Charge register is local; other addresses read from outside
    assign rd_addr = st_ff.ptr;
    assign rd_byte = (st_ff.ptr == TRICKLE_ADDR) ? st_ff.tcc : rd_data;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sclk_d = sclk_s;
        nxt_st.four_wire = strap_s;
        if (st_ff.req_v && fifo_ready) begin
            nxt_st.req_v = 1'b0;
        end
        if (!ce_s) begin
            // Dropping enable aborts any partial byte and releases the line
            nxt_st.phase   = SRAP_IDLE;
            nxt_st.driving = 1'b0;
            nxt_st.sdo_o   = 1'b0;
        end else begin
            unique case (st_ff.phase)
                SRAP_IDLE: begin
                    nxt_st.phase    = SRAP_ADDR;
                    nxt_st.idle_pol = sclk_s;
                    nxt_st.bit_cnt  = 3'h0;
                end
                SRAP_ADDR, SRAP_DATA: begin
                    if (strobe) begin
                        nxt_st.shift   = byte_in;
                        nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                        if (st_ff.bit_cnt == BIT_LAST) begin
                            nxt_st.bit_cnt = 3'h0;
                            if (st_ff.phase == SRAP_ADDR) begin
                                nxt_st.phase = SRAP_DATA;
                                nxt_st.write = byte_in[ADDR_RW_BIT];
                                nxt_st.ptr   = byte_in[6:0];
                                nxt_st.tx    = 8'h00;
                            end else begin
                                nxt_st.ptr = ptr_inc;
                                if (st_ff.write) begin
                                    nxt_st.req_v       = 1'b1;
                                    nxt_st.req_q.write = 1'b1;
                                    nxt_st.req_q.addr  = st_ff.ptr;
                                    nxt_st.req_q.data  = byte_in;
                                    if (st_ff.ptr == TRICKLE_ADDR) begin
                                        nxt_st.tcc = byte_in;
                                    end
                                end
                            end
                        end
                    end
                    // Read data leaves on the shift edge; load happens at bit 0
                    if (shift_edge && st_ff.phase == SRAP_DATA && !st_ff.write) begin
                        nxt_st.driving = 1'b1;
                        if (st_ff.bit_cnt == 3'h0) begin
                            nxt_st.sdo_o = st_ff.four_wire ? rd_byte[7] : rd_byte[0];
                            nxt_st.tx    = st_ff.four_wire ? {rd_byte[6:0], 1'b0}
                                                           : {1'b0, rd_byte[7:1]};
                        end else begin
                            nxt_st.sdo_o = st_ff.four_wire ? st_ff.tx[7] : st_ff.tx[0];
                            nxt_st.tx    = st_ff.four_wire ? {st_ff.tx[6:0], 1'b0}
                                                           : {1'b0, st_ff.tx[7:1]};
                        end
                    end
                end
                default: nxt_st.phase = SRAP_IDLE;
            endcase
        end
        // Alarm flags: pointer landing clears, a new match wins over the clear
        if (st_ff.phase == SRAP_DATA && ce_s) begin
            if (st_ff.ptr >= ALM_A_FIRST && st_ff.ptr <= ALM_A_LAST) begin
                nxt_st.flag_a = 1'b0;
            end
            if (st_ff.ptr >= ALM_B_FIRST && st_ff.ptr <= ALM_B_LAST) begin
                nxt_st.flag_b = 1'b0;
            end
        end
        if (alarm_a_set) begin
            nxt_st.flag_a = 1'b1;
        end
        if (alarm_b_set) begin
            nxt_st.flag_b = 1'b1;
        end
        nxt_st.irq_a = st_ff.flag_a && alarm_a_irq_en;
        nxt_st.irq_b = st_ff.flag_b && alarm_b_irq_en;
        // Charger decode from the stored control byte
        nxt_st.chg.enable = (st_ff.tcc[7:4] == CHARGE_KEY)
                         && (st_ff.tcc[3:2] == DIODE_NONE || st_ff.tcc[3:2] == DIODE_ONE)
                         && (st_ff.tcc[1:0] != SEL_NONE);
        nxt_st.chg.one_diode = (st_ff.tcc[3:2] == DIODE_ONE);
        nxt_st.chg.resistor  = st_ff.tcc[1:0];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff     <= '0;
            st_ff.tcc <= TRICKLE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Write path buffer; a full buffer holds the pending write
    // ------------------------------------------------------------
    logic req_v_o;
    srap_req_t req_o;
    logic fifo_pop;

    srap_fifo #(
        .WIDTH ($bits(srap_req_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_n),
        .in_valid  (st_ff.req_v),
        .in_ready  (fifo_ready),
        .in_data   (st_ff.req_q),
        .out_valid (req_v_o),
        .out_ready (fifo_pop),
        .out_data  (req_o)
    );

    // Head moves out only into an empty or just-taken stage, so a stall drops nothing
    assign fifo_pop = req_v_o && (!req_valid || req_ready);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_valid <= 1'b0;
            req       <= '0;
        end else if (fifo_pop) begin
            req_valid <= 1'b1;
            req       <= req_o;
        end else if (req_ready) begin
            req_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sdo                    = st_ff.sdo_o;
    assign sdo_oe                 = st_ff.driving;
    assign alarm_a_flag           = st_ff.flag_a;
    assign alarm_b_flag           = st_ff.flag_b;
    assign irq_out_a              = 1'b0;
    assign irq_out_a_oe           = st_ff.irq_a;
    assign irq_out_b              = 1'b0;
    assign irq_out_b_oe           = st_ff.irq_b;
    assign trickle_charge_control = st_ff.tcc;
    assign charge                 = st_ff.chg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_key;
        @(posedge clk) disable iff (!rst_n)
        st_ff.tcc[7:4] != CHARGE_KEY |=> !charge.enable;
    endproperty
    a_key: assert property (p_key) else $error("charger on without key");

    property p_reset_tcc;
        @(posedge clk) $rose(rst_n) |-> trickle_charge_control == TRICKLE_RESET;
    endproperty
    a_reset_tcc: assert property (p_reset_tcc) else $error("charge reg not zero");

    property p_diode;
        @(posedge clk) disable iff (!rst_n)
        (st_ff.tcc[3:2] == 2'h0 || st_ff.tcc[3:2] == 2'h3) |=> !charge.enable;
    endproperty
    a_diode: assert property (p_diode) else $error("bad diode enables");

    property p_res;
        @(posedge clk) disable iff (!rst_n)
        st_ff.tcc[1:0] == SEL_NONE |=> !charge.enable;
    endproperty
    a_res: assert property (p_res) else $error("zero resistor enables");

    property p_abort;
        @(posedge clk) disable iff (!rst_n)
        !ce_s |=> st_ff.phase == SRAP_IDLE && !sdo_oe;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort on enable low");

    property p_nodrive_write;
        @(posedge clk) disable iff (!rst_n)
        st_ff.write && st_ff.phase == SRAP_DATA |-> !sdo_oe;
    endproperty
    a_nodrive_write: assert property (p_nodrive_write) else $error("drive in write");

    property p_wrap_rtc;
        @(posedge clk) disable iff (!rst_n)
        ce_s && st_ff.phase == SRAP_DATA && strobe && st_ff.bit_cnt == BIT_LAST
            && st_ff.ptr == RTC_LAST |=> st_ff.ptr == RTC_FIRST;
    endproperty
    a_wrap_rtc: assert property (p_wrap_rtc) else $error("clock wrap wrong");

    property p_wrap_ram;
        @(posedge clk) disable iff (!rst_n)
        ce_s && st_ff.phase == SRAP_DATA && strobe && st_ff.bit_cnt == BIT_LAST
            && st_ff.ptr == RAM_LAST |=> st_ff.ptr == RAM_FIRST;
    endproperty
    a_wrap_ram: assert property (p_wrap_ram) else $error("ram wrap wrong");

    property p_irq_od;
        @(posedge clk) disable iff (!rst_n)
        !irq_out_a && !irq_out_b && irq_out_a_oe == $past(alarm_a_flag && alarm_a_irq_en)
            && irq_out_b_oe == $past(alarm_b_flag && alarm_b_irq_en);
    endproperty
    a_irq_od: assert property (p_irq_od) else $error("irq drives high");
endmodule

// ### srap_master_model.sv
module srap_master_model (
    // Pacing clock
    input  wire logic clk,
    // Serial pins toward the port
    output logic      sclk,
    output logic      ce,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe,
    input  wire logic three_wire
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       m_oe;
    logic       m_bit;
    logic [7:0] wq[$];
    logic [7:0] rq[$];

    // Released line shows slave data in three-wire while it drives, else the inverse of the last bit so a stale value never passes
    assign sdi = m_oe ? m_bit : ((three_wire && sdo_oe) ? sdo : ~m_bit);

    initial begin
        sclk = 1'b0;
        ce = 1'b0;
        m_oe = 1'b0;
        m_bit = 1'b0;
    end

    // One byte: clock pulses only here, one clock per bit; frame only sets the idle level
    task automatic byte_io(input logic idle, input logic drv, input logic [7:0] tx,
                           output logic [7:0] rx);
        int b;
        for (int i = 0; i < 8; i++) begin
            b = three_wire ? i : 7 - i;
            @(negedge clk);
            m_oe = drv;
            m_bit = drv ? tx[b] : m_bit;
            sclk = three_wire ? 1'b0 : ~idle;
            repeat (12) @(negedge clk);
            rx[b] = sdo_oe ? sdo : 1'bx;
            sclk = three_wire ? 1'b1 : idle;
            repeat (12) @(negedge clk);
            sclk = three_wire ? 1'b0 : sclk;
        end
    endtask

    // -----------------------------------------------
    // Whole transaction framed by chip enable
    // -----------------------------------------------
    task automatic frame(input logic idle, input logic [7:0] addr, input int n);
        logic [7:0] rx;
        rq.delete();
        @(negedge clk);
        sclk = three_wire ? 1'b0 : idle;
        repeat (25) @(negedge clk);
        ce = 1'b1;
        repeat (25) @(negedge clk);
        byte_io(idle, 1'b1, addr, rx);
        for (int k = 0; k < n; k++) begin
            if (addr[7]) begin
                byte_io(idle, 1'b1, wq.pop_front(), rx);
            end else begin
                byte_io(idle, 1'b0, 8'h00, rx);
                rq.push_back(rx);
            end
        end
        repeat (12) @(negedge clk);
        ce = 1'b0;
        m_oe = 1'b0;
        repeat (25) @(negedge clk);
    endtask
endmodule

// ### serial_register_access_port_bench.sv
module serial_register_access_port_bench
    import srap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk, rst_b, sclk, ce, sdi, sdo, sdo_oe, strap;
    logic         req_valid, req_ready;
    srap_req_t    req;
    logic [6:0]   rd_addr;
    logic [7:0]   rd_data;
    logic         a_set, b_set, a_en, b_en, flag_a, flag_b;
    logic         irq_a, irq_a_oe, irq_b, irq_b_oe;
    logic [7:0]   tcc;
    srap_charge_t charge;
    logic [7:0]   mem [128];
    logic [7:0]   v;
    logic [7:0]   keys [10] = '{8'hA5, 8'hA6, 8'hA7, 8'hA9, 8'hAA, 8'hAB, 8'hA1, 8'hAD,
                                8'hA4, 8'h5A};
    logic         en;
    int           n_fail, checks_done, cycles;

    srap_top u_srap_top (
        .clk(clk), .rst_b(rst_b), .sclk(sclk), .ce(ce), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .interface_select_strap(strap), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rd_addr(rd_addr), .rd_data(rd_data),
        .alarm_a_set(a_set), .alarm_b_set(b_set), .alarm_a_irq_en(a_en),
        .alarm_b_irq_en(b_en), .alarm_a_flag(flag_a), .alarm_b_flag(flag_b),
        .irq_out_a(irq_a), .irq_out_a_oe(irq_a_oe), .irq_out_b(irq_b),
        .irq_out_b_oe(irq_b_oe), .trickle_charge_control(tcc), .charge(charge)
    );

    srap_master_model u_srap_master_model (
        .clk(clk), .sclk(sclk), .ce(ce), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .three_wire(~strap)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Register storage: commits only when a request is taken, so a stall shows
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (req_valid && req_ready) begin
            mem[req.addr] <= req.data;
        end
        if (cycles == 60000) begin
            n_fail = n_fail + 1;
            finish_test();
        end
    end
    assign rd_data = mem[rd_addr];

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic xfer(input logic idle, input logic [7:0] addr, input int n);
        u_srap_master_model.frame(idle, addr, n);
        repeat (20) @(negedge clk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // -----------------------------------------------
    // Main sequence
    // -----------------------------------------------
    initial begin
        {rst_b, a_set, b_set, a_en, b_en} = '0;
        {strap, req_ready} = 2'b11;
        {n_fail, checks_done, cycles} = '0;
        for (int a = 0; a < 128; a++) mem[a] = 8'(a) ^ 8'h5A;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (10) @(negedge clk);
        chk("tcc_reset", TRICKLE_RESET, tcc);
        chk("charge_reset", 8'h00, 8'(charge));
        chk("oe_idle", 8'h00, 8'(sdo_oe));
        // Both clock idle levels alternate through the charge table
        foreach (keys[i]) begin
            v = keys[i];
            en = v[7:4] == 4'hA && (v[3:2] == 2'h1 || v[3:2] == 2'h2) && v[1:0] != 2'h0;
            u_srap_master_model.wq.push_back(v);
            xfer(1'(i), {1'b1, TRICKLE_ADDR}, 1);
            chk("tcc", v, tcc);
            chk("charge_en", 8'(en), 8'(charge.enable));
            if (en) chk("sel", {v[3:2] == 2'h2, v[1:0]}, {charge.one_diode, charge.resistor});
        end
        xfer(1'b1, {1'b0, TRICKLE_ADDR}, 1);
        chk("tcc_read", 8'h5A, u_srap_master_model.rq[0]);
        xfer(1'b0, 8'h7E, 3);
        for (int k = 0; k < 3; k++) begin
            v = (k == 2) ? 8'h20 : 8'h7E + 8'(k);
            chk("ram_burst", v ^ 8'h5A, u_srap_master_model.rq[k]);
        end
        // Storage stalls during an RTC burst that wraps
        req_ready = 1'b0;
        u_srap_master_model.wq = '{8'hC1, 8'hC2, 8'hC3};
        xfer(1'b0, 8'h9E, 3);
        chk("stall", 8'h1F ^ 8'h5A, mem[31]);
        req_ready = 1'b1;
        repeat (20) @(negedge clk);
        chk("rtc_1e", 8'hC1, mem[30]);
        chk("rtc_1f", 8'hC2, mem[31]);
        chk("rtc_00", 8'hC3, mem[0]);
        chk("req_idle", 8'h00, 8'(req_valid));
        // Alarm flags, open-drain pins and clear by pointer
        {a_en, a_set, b_set} = 3'b111;
        @(negedge clk);
        {a_set, b_set} = 2'b00;
        repeat (4) @(negedge clk);
        chk("irq_a_oe", 8'h01, 8'(irq_a_oe));
        chk("irq_a", 8'h00, 8'(irq_a));
        chk("irq_b_oe", 8'h00, 8'(irq_b_oe));
        chk("irq_b", 8'h00, 8'(irq_b));
        xfer(1'b0, {1'b0, ALM_A_FIRST}, 1);
        chk("flag_a", 8'h00, 8'(flag_a));
        chk("flag_b", 8'h01, 8'(flag_b));
        chk("irq_a_off", 8'h00, 8'(irq_a_oe));
        u_srap_master_model.wq.push_back(8'h00);
        xfer(1'b0, {1'b1, ALM_B_LAST}, 1);
        chk("flag_b_clr", 8'h00, 8'(flag_b));
        // Three-wire: shared line, LSB first
        strap = 1'b0;
        repeat (10) @(negedge clk);
        u_srap_master_model.wq.push_back(8'h6B);
        xfer(1'b0, {1'b1, TRICKLE_ADDR}, 1);
        chk("tcc_3w", 8'h6B, tcc);
        xfer(1'b0, 8'h7F, 2);
        chk("ram_3w_7f", 8'h7F ^ 8'h5A, u_srap_master_model.rq[0]);
        chk("ram_3w_20", 8'h20 ^ 8'h5A, u_srap_master_model.rq[1]);
        chk("oe_end", 8'h00, 8'(sdo_oe));
        finish_test();
    end
endmodule
